// [core/mode_ctrl_defines.svh]
// constants for the read channel mode control block
`ifndef MODE_CTRL_DEFINES_SVH
`define MODE_CTRL_DEFINES_SVH
`define ADDR_CTRL_OP      8'h00
`define ADDR_CTRL_TEST    8'h04
`define ADDR_PWR_DOWN     8'h08
`define ADDR_STATUS       8'h0c
`define ADDR_WRITE_DATA   8'h10
`define CTRL_OP_RESET     32'h0000_0000
`define CTRL_TEST_RESET   32'h0000_0000
`define PWR_DOWN_RESET    32'h0000_0000
`define BIT_VCO_BYPASS    3
`define BIT_WG_POLARITY   0
`define BIT_TEST_DET      0
`define PWR_DOWN_WIDTH    8
`define NRZ_WIDTH         9
`define SYNC_STAGES       2
`define SYNC_WIDTH        9
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10
`endif

// [core/mode_ctrl_pkg.sv]
// types for the read channel mode control block
package mode_ctrl_pkg;
    typedef enum logic [1:0]
    {
        MODE_IDLE,
        MODE_READ,
        MODE_WRITE,
        MODE_SERVO
    } chan_mode_t;
endpackage

// [core/read_channel_mode_control.sv]
// read channel mode control: gate decode, clock source steering, write data capture, axi-lite registers
// Contract
// - Use data gain capacitor while servo gate low, servo capacitor while high.
// - Impedance-drop input high lowers input impedance; low keeps it high.
// - Open control inputs read as logic high on the listed pins.
// - Fast-decay input high puts gain charge pump in fast decay mode.
// - Sleep low shuts everything down except the serial configuration port; code keeps eq_taps_frozen, capacitor selects and clock muxes live.
// - While sleep high, only sections chosen in power-down register shut down.
// - Gain-hold low disables gain charge pump; loop active when high or open.
// - Equalizer-freeze high holds tap weights until it returns low.
// - Vco-bypass bit 3 set feeds reference frequency to data separator.
// - Capture write data on each rising edge of the write clock.
// - Read gate rise selects read data, starts sync and read sequences.
// - Read gate low uses time base generator output as pll reference.
// - Write mode when write gate at the level set by polarity bit.
// - Servo gate high enters servo read mode.
// - Test detector input reaches back end only when test bit selects it.
// - Direct-write-2 enable low connects direct write inputs to write flip-flop.
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`include "mode_ctrl_defines.svh"
module read_channel_mode_control
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic        read_gate,
    input  wire logic        write_gate,
    input  wire logic        servo_gate,
    input  wire logic        impedance_drop,
    input  wire logic        fast_decay_control,
    input  wire logic        sleep_control,
    input  wire logic        gain_hold_n,
    input  wire logic        equalizer_freeze,
    input  wire logic        direct_write2_enable,
    input  wire logic        direct_write_inputs,
    input  wire logic        test_detector_input,
    input  wire logic        reference_frequency_in,
    input  wire logic        vco_in,
    input  wire logic        tbg_in,
    input  wire logic        read_data_in,
    input  wire logic        write_clock,
    input  wire logic [8:0]  nrz_in,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             data_gain_capacitor,
    output logic             servo_gain_capacitor,
    output logic             low_impedance_en,
    output logic             fast_decay_en,
    output logic             gain_pump_en,
    output logic             eq_taps_frozen,
    output logic [7:0]       section_shutdown,
    output logic             chip_asleep,
    output logic             separator_source,
    output logic             pll_ref_source,
    output logic             pll_sync_start,
    output logic             read_mode,
    output logic             write_mode,
    output logic             servo_mode,
    output logic             backend_test_data,
    output logic             write_ff_data,
    output logic             write_ff_direct,
    output logic [8:0]       write_data_latched
);
    // synchroniser, bit order below
    logic [8:0] sync1_reg;
    logic [8:0] sync2_reg;
    logic       rg_d_reg;
    logic       wclk_d_reg;
    logic [31:0] ctrl_op_reg;
    logic [31:0] ctrl_test_reg;
    logic [31:0] pwr_down_reg;
    logic        aw_held_reg;
    logic        w_held_reg;
    logic [7:0]  aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    mode_ctrl_pkg::chan_mode_t mode_reg;
    mode_ctrl_pkg::chan_mode_t mode_next;
    logic rg_s, wg_s, sg_s, lz_s, fd_s, sl_s, gh_s, eq_s, dw_s;
    logic wg_active;
    logic do_write;

    // byte-lane merge of a write
    function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] nw,
                                                input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                r[8*i +: 8] = nw[8*i +: 8];
        return r;
    endfunction

    // two-stage synchronisers on gate and hold pins
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_reg <= 9'h1ff; // open pins idle high
            sync2_reg <= 9'h1ff;
        end
        else if (clk_en)
        begin
            sync1_reg <= {dw_in_w(), eq_in_w(), gain_hold_n, sleep_control, fast_decay_control,
                          impedance_drop, servo_gate, write_gate, read_gate};
            sync2_reg <= sync1_reg;
        end
    end
    function automatic logic dw_in_w();
        return direct_write2_enable;
    endfunction
    function automatic logic eq_in_w();
        return equalizer_freeze;
    endfunction
    assign {dw_s, eq_s, gh_s, sl_s, fd_s, lz_s, sg_s, wg_s, rg_s} = sync2_reg;
    assign wg_active = (wg_s != ctrl_op_reg[`BIT_WG_POLARITY]); // polarity bit set: active low

    // mode decode, servo outranks write outranks read
    always_comb
    begin
        mode_next = mode_ctrl_pkg::MODE_IDLE;
        if (!sl_s)
            mode_next = mode_ctrl_pkg::MODE_IDLE;
        else if (sg_s)
            mode_next = mode_ctrl_pkg::MODE_SERVO;
        else if (wg_active)
            mode_next = mode_ctrl_pkg::MODE_WRITE;
        else if (rg_s)
            mode_next = mode_ctrl_pkg::MODE_READ;
    end

    // mode register and gate edge tracking
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_reg <= mode_ctrl_pkg::MODE_IDLE;
            rg_d_reg <= 1'b1;
            pll_sync_start <= 1'b0;
        end
        else if (clk_en)
        begin
            mode_reg <= mode_next;
            rg_d_reg <= rg_s;
            pll_sync_start <= rg_s && !rg_d_reg && sl_s; // read gate rise
        end
    end

    // analog steering outputs
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            data_gain_capacitor  <= 1'b0;
            servo_gain_capacitor <= 1'b1;
            low_impedance_en     <= 1'b1;
            fast_decay_en        <= 1'b1;
            gain_pump_en         <= 1'b1;
            eq_taps_frozen       <= 1'b1;
            chip_asleep          <= 1'b0;
            section_shutdown     <= 8'h00;
            read_mode            <= 1'b0;
            write_mode           <= 1'b0;
            servo_mode           <= 1'b0;
        end
        else if (clk_en)
        begin
            data_gain_capacitor  <= !sg_s;
            servo_gain_capacitor <= sg_s;
            low_impedance_en     <= lz_s && sl_s;
            fast_decay_en        <= fd_s && sl_s;
            gain_pump_en         <= gh_s && sl_s;
            eq_taps_frozen       <= eq_s;
            chip_asleep          <= !sl_s;
            section_shutdown     <= sl_s ? pwr_down_reg[7:0] : 8'hff;
            read_mode            <= (mode_next == mode_ctrl_pkg::MODE_READ);
            write_mode           <= (mode_next == mode_ctrl_pkg::MODE_WRITE);
            servo_mode           <= (mode_next == mode_ctrl_pkg::MODE_SERVO);
        end
    end

    // clock source and data path muxes
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            separator_source  <= 1'b0;
            pll_ref_source    <= 1'b0;
            backend_test_data <= 1'b0;
            write_ff_data     <= 1'b0;
            write_ff_direct   <= 1'b0;
        end
        else if (clk_en)
        begin
            separator_source  <= ctrl_op_reg[`BIT_VCO_BYPASS] ? reference_frequency_in : vco_in;
            pll_ref_source    <= rg_s ? read_data_in : tbg_in;
            backend_test_data <= ctrl_test_reg[`BIT_TEST_DET] & test_detector_input;
            write_ff_direct   <= !dw_s;
            write_ff_data     <= !dw_s ? direct_write_inputs : write_data_latched[0];
        end
    end

    // nrz capture on rising write clock edges, sampled in the core clock
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wclk_d_reg         <= 1'b1;
            write_data_latched <= 9'h000;
        end
        else if (clk_en)
        begin
            wclk_d_reg <= write_clock;
            if (write_clock && !wclk_d_reg)
                write_data_latched <= nrz_in;
        end
    end

    // axi-lite write channel
    assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_held_reg   <= 1'b0;
            w_held_reg    <= 1'b0;
            aw_addr_reg   <= 8'h00;
            w_data_reg    <= 32'h0000_0000;
            w_strb_reg    <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            ctrl_op_reg   <= `CTRL_OP_RESET;
            ctrl_test_reg <= `CTRL_TEST_RESET;
            pwr_down_reg  <= `PWR_DOWN_RESET;
        end
        else if (clk_en)
        begin
            s_axi_awready <= !aw_held_reg && !s_axi_awready;
            s_axi_wready  <= !w_held_reg && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `RESP_OKAY;
                case (aw_addr_reg)
                    `ADDR_CTRL_OP:   ctrl_op_reg   <= merge_bytes(ctrl_op_reg, w_data_reg, w_strb_reg);
                    `ADDR_CTRL_TEST: ctrl_test_reg <= merge_bytes(ctrl_test_reg, w_data_reg, w_strb_reg);
                    `ADDR_PWR_DOWN:  pwr_down_reg  <= merge_bytes(pwr_down_reg, w_data_reg, w_strb_reg);
                    `ADDR_STATUS, `ADDR_WRITE_DATA: s_axi_bresp <= `RESP_OKAY;
                    default:         s_axi_bresp   <= `RESP_SLVERR;
                endcase
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // axi-lite read channel
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RESP_OKAY;
        end
        else if (clk_en)
        begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `RESP_OKAY;
                case (s_axi_araddr)
                    `ADDR_CTRL_OP:    s_axi_rdata <= ctrl_op_reg;
                    `ADDR_CTRL_TEST:  s_axi_rdata <= ctrl_test_reg;
                    `ADDR_PWR_DOWN:   s_axi_rdata <= pwr_down_reg;
                    `ADDR_STATUS:     s_axi_rdata <= {21'h000000, mode_reg, sync2_reg};
                    `ADDR_WRITE_DATA: s_axi_rdata <= {23'h000000, write_data_latched};
                    default:
                    begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `RESP_SLVERR;
                    end
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // checks
    a_servo_cap: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en [*3] ##1 $past(rst_n, 3) |->
        (servo_gain_capacitor == $past(servo_gate, 3)) && (data_gain_capacitor != servo_gain_capacitor))
        else $error("servo capacitor select wrong");
    a_sleep_all: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en [*3] ##1 !$past(sleep_control, 3) |-> chip_asleep && section_shutdown == 8'hff && !gain_pump_en)
        else $error("sleep did not shut down");
    a_pwr_sel: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && sl_s |=> !clk_en || section_shutdown == $past(pwr_down_reg[7:0]))
        else $error("power down selection wrong");
    a_bypass_src: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && ctrl_op_reg[3] |=> !clk_en || separator_source == $past(reference_frequency_in))
        else $error("vco bypass not applied");
    a_sync_pulse: assert property (@(posedge clock) disable iff (!rst_n)
        pll_sync_start |-> !$past(pll_sync_start) && rg_d_reg)
        else $error("sync start not a single pulse");
    a_write_pol: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && sl_s && !sg_s && (wg_s != ctrl_op_reg[0]) |=> !clk_en || write_mode)
        else $error("write mode not entered");
    a_servo_rank: assert property (@(posedge clock) disable iff (!rst_n)
        servo_mode |-> !write_mode && !read_mode)
        else $error("modes overlap");
    a_nrz_catch: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && write_clock && !wclk_d_reg |=> write_data_latched == $past(nrz_in))
        else $error("write data not captured");
    a_test_route: assert property (@(posedge clock) disable iff (!rst_n)
        backend_test_data |-> $past(ctrl_test_reg[0]))
        else $error("test detector leaked");
    a_direct_wr: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && !dw_s |=> !clk_en || (write_ff_direct && write_ff_data == $past(direct_write_inputs)))
        else $error("direct write not routed");
    c_read_start: cover property (@(posedge clock) disable iff (!rst_n) pll_sync_start ##1 read_mode);
    c_servo: cover property (@(posedge clock) disable iff (!rst_n) servo_mode);
    c_write: cover property (@(posedge clock) disable iff (!rst_n) write_mode && s_axi_bvalid);
    c_sleep: cover property (@(posedge clock) disable iff (!rst_n) chip_asleep);
endmodule

// [verif/disk_controller_model.sv]
// disk controller model: gates, sleep pin, write clock and nrz write data
module disk_controller_model
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       want_read,
    input  wire logic       want_write,
    input  wire logic       want_servo,
    input  wire logic       want_sleep,
    input  wire logic       gate_low_active,
    input  wire logic       send_req,
    input  wire logic [8:0] send_byte,
    output logic            busy,
    output logic            read_gate,
    output logic            write_gate,
    output logic            servo_gate,
    output logic            sleep_control,
    output logic            write_clock,
    output logic [8:0]      nrz_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_reg;

    // gate levels follow the requested mode
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            read_gate     <= 1'b0;
            write_gate    <= 1'b0;
            servo_gate    <= 1'b0;
            sleep_control <= 1'b1; // driven high, no pull-up inside
        end
        else
        begin
            read_gate     <= want_read;
            write_gate    <= want_write ^ gate_low_active;
            servo_gate    <= want_servo;
            sleep_control <= !want_sleep; // high unless sleep asked
        end
    end

    // one write clock pulse per byte, data set up well before the rise
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_reg     <= 4'h0;
            write_clock <= 1'b0;
            nrz_in      <= 9'h000;
        end
        else if (cnt_reg == 4'h0)
        begin
            if (send_req)
            begin
                nrz_in  <= send_byte;
                cnt_reg <= 4'h1;
            end
        end
        else
        begin
            cnt_reg     <= cnt_reg + 4'h1;
            write_clock <= (cnt_reg >= 4'h4) && (cnt_reg < 4'h8);
            if (cnt_reg == 4'h9)
            begin
                nrz_in  <= ~nrz_in; // bus inverted after the pulse, so it shows no stale data
                cnt_reg <= 4'h0;
            end
        end
    end

    assign busy = cnt_reg != 4'h0;
endmodule

// [verif/testbench.sv]
// testbench for the read channel mode control block
`include "mode_ctrl_defines.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, rst_n = 1'b0, clk_en = 1'b1, impedance_drop = 1'b0, fast_decay_control = 1'b0;
    logic gain_hold_n = 1'b1, equalizer_freeze = 1'b0, direct_write2_enable = 1'b1, direct_write_inputs = 1'b0;
    logic test_detector_input = 1'b1, reference_frequency_in = 1'b1, vco_in = 1'b0, tbg_in = 1'b0;
    logic read_data_in = 1'b1, want_read = 1'b0, want_write = 1'b0, want_servo = 1'b0, want_sleep = 1'b0;
    logic gate_low_active = 1'b0, send_req = 1'b0, busy, read_gate, write_gate, servo_gate, sleep_control;
    logic write_clock, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [8:0]  send_byte = 9'h000, nrz_in, write_data_latched;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, section_shutdown;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic data_gain_capacitor, servo_gain_capacitor, low_impedance_en, fast_decay_en, gain_pump_en;
    logic eq_taps_frozen, chip_asleep, separator_source, pll_ref_source, pll_sync_start, read_mode;
    logic write_mode, servo_mode, backend_test_data, write_ff_data, write_ff_direct;
    int   n_errors = 0, checks = 0, cycles = 0, pulses = 0, pulses_base = 0;

    read_channel_mode_control i_dut (.clock, .rst_n, .clk_en, .read_gate, .write_gate, .servo_gate,
        .impedance_drop, .fast_decay_control, .sleep_control, .gain_hold_n, .equalizer_freeze,
        .direct_write2_enable, .direct_write_inputs, .test_detector_input, .reference_frequency_in, .vco_in,
        .tbg_in, .read_data_in, .write_clock, .nrz_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .data_gain_capacitor, .servo_gain_capacitor, .low_impedance_en, .fast_decay_en,
        .gain_pump_en, .eq_taps_frozen, .section_shutdown, .chip_asleep, .separator_source, .pll_ref_source,
        .pll_sync_start, .read_mode, .write_mode, .servo_mode, .backend_test_data, .write_ff_data,
        .write_ff_direct, .write_data_latched);
    disk_controller_model i_ctrl (.clock, .rst_n, .want_read, .want_write, .want_servo, .want_sleep,
        .gate_low_active, .send_req, .send_byte, .busy, .read_gate, .write_gate, .servo_gate,
        .sleep_control, .write_clock, .nrz_in);

    // clock, sync pulse counter and hang guard
    always #2 clock = ~clock;
    always @(posedge clock)
    begin
        if (pll_sync_start === 1'b1) pulses = pulses + 1;
        cycles = cycles + 1;
        if (cycles == 5000)
        begin
            n_errors++;
            summarize();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever
        begin
            @(posedge clock);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever
        begin
            @(posedge clock);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        v = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // pin effects land three edges after the pin, one more via the model
    task automatic settle;
        repeat (5) @(posedge clock);
    endtask

    task automatic send(input logic [8:0] b);
        @(posedge clock);
        send_req <= 1'b1;
        send_byte <= b;
        @(posedge clock);
        send_req <= 1'b0;
        @(posedge clock);
        while (busy) @(posedge clock);
        settle();
    endtask

    task automatic summarize;
        if (n_errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // main sequence
    initial
    begin
        repeat (6) @(posedge clock);
        check("servo cap in reset", 32'h1, servo_gain_capacitor);
        check("low-z in reset", 32'h1, low_impedance_en);
        check("fast decay in reset", 32'h1, fast_decay_en);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        axi_read(`ADDR_CTRL_OP, d, r);
        check("ctrl op reset", `CTRL_OP_RESET, d);
        axi_read(`ADDR_PWR_DOWN, d, r);
        check("power down reset", `PWR_DOWN_RESET, d);
        axi_read(8'h20, d, r);
        check("unmapped read resp", `RESP_SLVERR, r);
        axi_write(8'h20, 32'h1, r);
        check("unmapped write resp", `RESP_SLVERR, r);
        settle();
        check("data cap", 32'h1, data_gain_capacitor);
        @(posedge clock);
        want_servo <= 1'b1;
        repeat (3) @(posedge clock);
        check("data cap before sync", 32'h1, data_gain_capacitor);
        settle();
        check("servo cap", 32'h1, servo_gain_capacitor);
        check("data cap off", 32'h0, data_gain_capacitor);
        check("servo mode", 32'h1, servo_mode);
        want_servo <= 1'b0;
        for (int v = 1; v >= 0; v--)
        begin
            @(posedge clock);
            impedance_drop <= v[0];
            fast_decay_control <= v[0];
            gain_hold_n <= !v[0];
            equalizer_freeze <= v[0];
            settle();
            check("low impedance", v, low_impedance_en);
            check("fast decay", v, fast_decay_en);
            check("gain pump", !v, gain_pump_en);
            check("eq freeze", v, eq_taps_frozen);
        end
        axi_write(`ADDR_PWR_DOWN, 32'h5a, r);
        settle();
        check("partial shutdown", 32'h5a, section_shutdown);
        want_sleep <= 1'b1;
        settle();
        check("asleep", 32'h1, chip_asleep);
        check("full shutdown", 32'hff, section_shutdown);
        axi_read(`ADDR_PWR_DOWN, d, r);
        check("port alive asleep", 32'h5a, d);
        want_sleep <= 1'b0;
        axi_write(`ADDR_CTRL_OP, 32'h8, r);
        settle();
        check("separator ref", 32'h1, separator_source);
        axi_write(`ADDR_CTRL_OP, 32'h0, r);
        settle();
        check("separator vco", 32'h0, separator_source);
        check("pll ref tbg", 32'h0, pll_ref_source);
        pulses_base = pulses;
        want_read <= 1'b1;
        settle();
        check("read mode", 32'h1, read_mode);
        check("pll ref data", 32'h1, pll_ref_source);
        @(posedge clock);
        check("sync pulses", 32'h1, pulses - pulses_base);
        want_read <= 1'b0;
        want_write <= 1'b1;
        settle();
        check("write mode high", 32'h1, write_mode);
        axi_write(`ADDR_CTRL_OP, 32'h1, r);
        gate_low_active <= 1'b1;
        settle();
        check("write mode low", 32'h1, write_mode);
        want_write <= 1'b0;
        settle();
        check("write mode off", 32'h0, write_mode);
        gate_low_active <= 1'b0;
        axi_write(`ADDR_CTRL_OP, 32'h0, r);
        check("test route off", 32'h0, backend_test_data);
        axi_write(`ADDR_CTRL_TEST, 32'h1, r);
        settle();
        check("test route on", 32'h1, backend_test_data);
        send(9'h1a5);
        check("latched data", 32'h1a5, write_data_latched);
        axi_read(`ADDR_WRITE_DATA, d, r);
        check("latched data reg", 32'h1a5, d);
        check("flop from nrz", 32'h1, write_ff_data);
        send(9'h0c2);
        check("latched again", 32'h0c2, write_data_latched);
        direct_write2_enable <= 1'b0;
        direct_write_inputs <= 1'b1;
        settle();
        check("direct select", 32'h1, write_ff_direct);
        check("direct data", 32'h1, write_ff_data);
        clk_en <= 1'b0;
        want_servo <= 1'b1;
        settle();
        check("servo frozen by enable", 32'h0, servo_mode);
        clk_en <= 1'b1;
        settle();
        check("servo after enable", 32'h1, servo_mode);
        summarize();
    end
endmodule
